// [verilog/tx_l4_csum_consts.svh]
`ifndef TX_L4_CSUM_CONSTS_SVH
`define TX_L4_CSUM_CONSTS_SVH

// Frame store geometry: one segment of up to 2048 bytes is held at a time.
`define PTR_W 11
`define MEM_DEPTH 2048

// Byte positions of the address fields, relative to the start of the IP header.
`define V4_SRC_OFF 11'h00c
`define V4_DST_OFF 11'h010
`define V4_ADDR_END 11'h014
`define V6_SRC_OFF 11'h008
`define V6_DST_OFF 11'h018
`define V6_ADDR_END 11'h028

// Type 0 routing header: length byte position, fixed first block, address size.
`define RH_LEN_OFF 11'h001
`define RH_FIRST_HDR 11'h008
`define ADDR6_BYTES 11'h010

// Positions inside the layer-4 header.
`define TCP_CSUM_OFF 11'h010
`define TCP_FLAGS_OFF 11'h00d
`define UDP_CSUM_OFF 11'h006
`define UDP_LEN_OFF 11'h004

// Upper-layer protocol numbers.
`define PROTO_TCP 8'h06
`define PROTO_UDP 8'h11

// TCP flag bits that segmentation may clear.
`define FLAG_PSH_BIT 3
`define FLAG_FIN_BIT 0

// Checksum constants and the last step of the final fold.
`define CSUM_ALL_ONES 16'hffff
`define FOLD_LAST_STEP 3'h4

`endif

// [verilog/tx_l4_csum_pkg.sv]
package tx_l4_csum_pkg;

  `include "tx_l4_csum_consts.svh"

  // Segment handling phases.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_FOLD = 2'b10,
    ST_SEND = 2'b11
  } csum_state_e;

  // All state of the checksum block.
  typedef struct packed {
    csum_state_e st;
    logic hw_pseudo;
    logic ipv6;
    logic udp;
    logic ins;
    logic rh_present;
    logic rh_known;
    logic seg_last;
    logic [`PTR_W-1:0] ip_off;
    logic [`PTR_W-1:0] l4_off;
    logic [`PTR_W-1:0] rh_off;
    logic [`PTR_W-1:0] rh_last;
    logic [`PTR_W-1:0] wr_ptr;
    logic [`PTR_W-1:0] rd_ptr;
    logic [`PTR_W-1:0] last_ptr;
    logic [19:0] rem;
    logic [15:0] tcp_len;
    logic [15:0] udp_len;
    logic [15:0] l4_sum;
    logic [15:0] src_sum;
    logic [15:0] dst_sum;
    logic [15:0] rh_sum;
    logic [15:0] csum;
    logic [2:0] step;
    logic desc_ready;
    logic in_ready;
    logic out_valid;
    logic out_last;
    logic out_seg_last;
    logic [7:0] out_data;
  } csum_regs_s;

endpackage : tx_l4_csum_pkg

// [verilog/ones_complement_add.sv]
`timescale 1ns/10ps

// One's complement 16-bit adder with end-around carry.
module ones_complement_add (
  // Operands
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  // Folded sum
  output logic [15:0] y
);

  logic [16:0] raw;

  // A single carry fold suffices: the refolded value can never carry again.
  always_comb begin
    raw = {1'b0, a} + {1'b0, b};
    y = raw[15:0] + {15'h0000, raw[16]};
  end

endmodule : ones_complement_add

// [verilog/tx_l4_pseudo_header_checksum.sv]
`timescale 1ns/10ps
`include "tx_l4_csum_consts.svh"

// Notes on behaviour
// - Add layer-4 length into software seeded sum.
// - Sum header, payload, pseudo header one's complement.
// - Protocol byte goes into low sum byte.
// - TCP length is min(MSS, remaining) plus header.
// - Length counts header and data, not pseudo.
// - Full MSS per segment, last takes remainder.
// - Only push and finish flags may change.
// - IPv4 pseudo: source, destination, zero, protocol, length.
// - IPv6 pseudo: source, final destination, length, next.
// - Routing header present: use its last address.
// - IPv6 length: TCP computed, UDP length field.
// - IPv6 UDP zero result becomes all ones.
// - Routing length in 8-octet units, 128-bit addresses.
// - UDP header is fixed eight bytes.
// - UDP checksum written only when insert flag set.
module tx_l4_pseudo_header_checksum (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Segment descriptor, taken with seg_start while desc_ready is high
  input wire logic seg_start,
  input wire logic ipv6_sel,
  input wire logic udp_sel,
  input wire logic l4_checksum_insert_flag,
  input wire logic hw_pseudo,
  input wire logic tso_enable,
  input wire logic tso_first,
  input wire logic rh_present,
  input wire logic [`PTR_W-1:0] ip_offset,
  input wire logic [`PTR_W-1:0] l4_offset,
  input wire logic [`PTR_W-1:0] rh_offset,
  input wire logic [15:0] mss,
  input wire logic [19:0] total_payload_length,
  input wire logic [7:0] l4_header_length_field,
  output logic desc_ready,
  // Incoming segment bytes
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  output logic in_ready,
  // Outgoing segment bytes
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  output logic out_seg_last,
  input wire logic out_ready
);

  tx_l4_csum_pkg::csum_regs_s r_reg;
  tx_l4_csum_pkg::csum_regs_s r_next;

  // Whole-segment store; a frame longer than the store wraps and is not supported.
  logic [7:0] frame_mem [0:`MEM_DEPTH-1];
  // Five running sums: one for each of the four sources of checksum words, and one for the fold.
  logic [15:0] lane_sum [0:4];
  logic [15:0] lane_word [0:4];
  logic [15:0] lane_out [0:4];

  // Handshake terms, field positions and scratch values of the next-state logic.
  logic accept;
  logic [7:0] store_byte;
  logic [7:0] sum_byte;
  logic [19:0] rem_eff;
  logic last_calc;
  logic [15:0] pay;
  logic [`PTR_W-1:0] idx;
  logic [`PTR_W-1:0] cpos;
  logic [`PTR_W-1:0] src_lo;
  logic [`PTR_W-1:0] dst_lo;
  logic [`PTR_W-1:0] dst_hi;
  logic [15:0] result;
  logic load_ok;

  // Places a byte in the high lane at even offsets and the low lane at odd ones.
  function automatic logic [15:0] place(input logic [7:0] b, input logic odd);
    place = odd ? {8'h00, b} : {b, 8'h00};
  endfunction : place

  // Accumulator lanes: layer-4 bytes, source, destination, routing address, fold.
  assign lane_sum[0] = r_reg.l4_sum;
  assign lane_sum[1] = r_reg.src_sum;
  assign lane_sum[2] = r_reg.dst_sum;
  assign lane_sum[3] = r_reg.rh_sum;
  assign lane_sum[4] = r_reg.csum;

  // One end-around-carry adder per lane keeps every byte at one cycle.
  // Sharing one adder would cost four cycles a byte, so area is traded for rate.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_lane
      ones_complement_add u_add (
        .a(lane_sum[gi]),
        .b(lane_word[gi]),
        .y(lane_out[gi])
      );
    end
  endgenerate

  // Byte handshakes and field positions common to several processes.
  assign accept = r_reg.in_ready & in_valid;
  assign idx = r_reg.wr_ptr;
  assign load_ok = ~r_reg.out_valid | out_ready;
  // The checksum field sits at a fixed place in each layer-4 header.
  assign cpos = r_reg.l4_off + (r_reg.udp ? `UDP_CSUM_OFF : `TCP_CSUM_OFF);
  assign src_lo = r_reg.ip_off + (r_reg.ipv6 ? `V6_SRC_OFF : `V4_SRC_OFF);
  assign dst_lo = r_reg.ip_off + (r_reg.ipv6 ? `V6_DST_OFF : `V4_DST_OFF);
  assign dst_hi = r_reg.ip_off + (r_reg.ipv6 ? `V6_ADDR_END : `V4_ADDR_END);

  // Next-state logic for the whole block.
  always_comb begin
    r_next = r_reg;
    // The first segment of a job loads the whole payload; later ones use what is left.
    rem_eff = tso_first ? total_payload_length : r_reg.rem;
    last_calc = ~tso_enable | (rem_eff <= {4'h0, mss});
    pay = last_calc ? rem_eff[15:0] : mss;
    store_byte = in_data;
    sum_byte = in_data;
    result = 16'h0000;
    lane_word[0] = 16'h0000;
    lane_word[1] = 16'h0000;
    lane_word[2] = 16'h0000;
    lane_word[3] = 16'h0000;
    lane_word[4] = 16'h0000;
    // A byte taken downstream frees the output register for the next one.
    if (r_reg.out_valid && out_ready) begin
      r_next.out_valid = 1'b0;
    end
    unique case (r_reg.st)
      tx_l4_csum_pkg::ST_IDLE: begin
        // The descriptor is captured whole, so its inputs may change once it is taken.
        if (seg_start) begin
          r_next.st = tx_l4_csum_pkg::ST_RECV;
          r_next.hw_pseudo = hw_pseudo;
          r_next.ipv6 = ipv6_sel;
          r_next.udp = udp_sel;
          r_next.ins = l4_checksum_insert_flag;
          r_next.rh_present = rh_present & ipv6_sel;
          r_next.rh_known = 1'b0;
          r_next.seg_last = last_calc;
          r_next.ip_off = ip_offset;
          r_next.l4_off = l4_offset;
          r_next.rh_off = rh_offset;
          r_next.rem = last_calc ? 20'h00000 : rem_eff - {4'h0, mss};
          r_next.tcp_len = pay + {8'h00, l4_header_length_field};
          r_next.udp_len = 16'h0000;
          r_next.l4_sum = 16'h0000;
          r_next.src_sum = 16'h0000;
          r_next.dst_sum = 16'h0000;
          r_next.rh_sum = 16'h0000;
          r_next.wr_ptr = '0;
        end
      end
      tx_l4_csum_pkg::ST_RECV: begin
        if (accept) begin
          // Non-final segments drop push and finish; the other flags pass.
          if (!r_reg.udp && !r_reg.seg_last &&
              idx == r_reg.l4_off + `TCP_FLAGS_OFF) begin
            store_byte = in_data & ~(8'h01 << `FLAG_PSH_BIT) & ~(8'h01 << `FLAG_FIN_BIT);
          end
          // With a hardware-built pseudo header the seed bytes count as zero.
          sum_byte = store_byte;
          if (r_reg.hw_pseudo && (idx == cpos || idx == cpos + 11'h001)) begin
            sum_byte = 8'h00;
          end
          // Layer-4 header and payload, including any software seed.
          if (idx >= r_reg.l4_off) begin
            lane_word[0] = place(sum_byte, idx[0] ^ r_reg.l4_off[0]);
          end
          // Source address bytes.
          if (idx >= src_lo && idx < dst_lo) begin
            lane_word[1] = place(store_byte, idx[0] ^ r_reg.ip_off[0]);
          end
          // Destination address bytes from the IP header.
          if (idx >= dst_lo && idx < dst_hi) begin
            lane_word[2] = place(store_byte, idx[0] ^ r_reg.ip_off[0]);
          end
          // Routing header length gives the place of its last address.
          // A wrong length byte points at a wrong address; the block cannot tell.
          if (r_reg.rh_present && idx == r_reg.rh_off + `RH_LEN_OFF) begin
            r_next.rh_known = 1'b1;
            r_next.rh_last = r_reg.rh_off + {store_byte, 3'b000} +
                             `RH_FIRST_HDR - `ADDR6_BYTES;
          end
          // Final destination taken from the routing header's last entry.
          if (r_reg.rh_known && idx >= r_reg.rh_last &&
              idx < r_reg.rh_last + `ADDR6_BYTES) begin
            lane_word[3] = place(store_byte, idx[0] ^ r_reg.rh_last[0]);
          end
          // The UDP length field feeds the pseudo header length.
          if (r_reg.udp && idx == r_reg.l4_off + `UDP_LEN_OFF) begin
            r_next.udp_len[15:8] = store_byte;
          end
          if (r_reg.udp && idx == r_reg.l4_off + `UDP_LEN_OFF + 11'h001) begin
            r_next.udp_len[7:0] = store_byte;
          end
          // All four byte lanes advance on each byte; a lane that saw nothing adds zero.
          r_next.l4_sum = lane_out[0];
          r_next.src_sum = lane_out[1];
          r_next.dst_sum = lane_out[2];
          r_next.rh_sum = lane_out[3];
          r_next.wr_ptr = r_reg.wr_ptr + 11'h001;
          // The last byte closes the store and starts the fold.
          if (in_last) begin
            r_next.last_ptr = r_reg.wr_ptr;
            r_next.csum = 16'h0000;
            r_next.step = 3'h0;
            r_next.st = tx_l4_csum_pkg::ST_FOLD;
          end
        end
      end
      tx_l4_csum_pkg::ST_FOLD: begin
        // Five operands enter the fold adder one per cycle.
        // Operands left out in seeded mode add zero, so the fold always takes five cycles.
        unique case (r_reg.step)
          3'h0: lane_word[4] = r_reg.l4_sum;
          3'h1: lane_word[4] = r_reg.hw_pseudo ? r_reg.src_sum : 16'h0000;
          3'h2: begin
            if (r_reg.hw_pseudo) begin
              lane_word[4] = r_reg.rh_known ? r_reg.rh_sum : r_reg.dst_sum;
            end
          end
          3'h3: begin
            if (r_reg.hw_pseudo) begin
              lane_word[4] = {8'h00, r_reg.udp ? `PROTO_UDP : `PROTO_TCP};
            end
          end
          3'h4: lane_word[4] = r_reg.udp ? r_reg.udp_len : r_reg.tcp_len;
          default: lane_word[4] = 16'h0000;
        endcase
        r_next.csum = lane_out[4];
        r_next.step = r_reg.step + 3'h1;
        // The last step inverts; only IPv6 UDP must not send a zero result.
        if (r_reg.step == `FOLD_LAST_STEP) begin
          result = ~lane_out[4];
          if (r_reg.ipv6 && r_reg.udp && result == 16'h0000) begin
            result = `CSUM_ALL_ONES;
          end
          r_next.csum = result;
          r_next.rd_ptr = '0;
          r_next.st = tx_l4_csum_pkg::ST_SEND;
        end
      end
      tx_l4_csum_pkg::ST_SEND: begin
        // The output register reloads only when it is empty or being emptied.
        if (load_ok) begin
          r_next.out_valid = 1'b1;
          r_next.out_data = frame_mem[r_reg.rd_ptr];
          // High byte of the result leaves first.
          if (r_reg.ins && r_reg.rd_ptr == cpos) begin
            r_next.out_data = r_reg.csum[15:8];
          end
          if (r_reg.ins && r_reg.rd_ptr == cpos + 11'h001) begin
            r_next.out_data = r_reg.csum[7:0];
          end
          r_next.out_last = (r_reg.rd_ptr == r_reg.last_ptr);
          r_next.out_seg_last = r_reg.seg_last;
          r_next.rd_ptr = r_reg.rd_ptr + 11'h001;
          // Idle follows the last load, so the next descriptor may wait on the last byte.
          if (r_reg.rd_ptr == r_reg.last_ptr) begin
            r_next.st = tx_l4_csum_pkg::ST_IDLE;
          end
        end
      end
    endcase
    // Ready flags follow the next state, so they stand from the edge that enters it.
    r_next.in_ready = (r_next.st == tx_l4_csum_pkg::ST_RECV);
    r_next.desc_ready = (r_next.st == tx_l4_csum_pkg::ST_IDLE);
  end

  // State register; the frame store is written on the side.
  // The asynchronous reset clears all state, so every output starts low.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Store-and-forward buffer: the checksum sits before the payload on the wire,
  // so the whole segment must be seen before its first byte may leave.
  // The store needs no reset: a byte is read only after it has been written.
  always_ff @(posedge clk) begin
    if (accept) begin
      frame_mem[r_reg.wr_ptr] <= store_byte;
    end
  end

  // Outputs straight from the state register.
  assign desc_ready = r_reg.desc_ready;
  assign in_ready = r_reg.in_ready;
  assign out_valid = r_reg.out_valid;
  assign out_data = r_reg.out_data;
  assign out_last = r_reg.out_last;
  assign out_seg_last = r_reg.out_seg_last;

endmodule : tx_l4_pseudo_header_checksum

// [tb/csum_checker_sva.sv]
`timescale 1ns/10ps

// Port timing checks; all of them belong to the single clock domain.
module csum_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Descriptor and input stream
  input wire logic seg_start,
  input wire logic desc_ready,
  input wire logic in_valid,
  input wire logic in_last,
  input wire logic in_ready,
  // Output stream
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_seg_last,
  input wire logic out_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // The last byte taken, then five fold cycles and the load cycle before the first output byte.
  sequence last_in;
    in_valid && in_ready && in_last;
  endsequence
  sequence fold_gap;
    !out_valid [*6] ##1 out_valid;
  endsequence

  reset_quiet_a: assert property (disable iff (1'b0) !nrst |-> !desc_ready && !in_ready && !out_valid)
    else $error("outputs active during reset");
  desc_take_a: assert property (desc_ready && seg_start |=> !desc_ready && in_ready)
    else $error("descriptor not taken");
  in_hold_a: assert property (in_ready && !(in_valid && in_last) |=> in_ready)
    else $error("input stream stopped early");
  in_end_a: assert property (last_in |=> !in_ready)
    else $error("input still open after last byte");
  fold_time_a: assert property (last_in |=> fold_gap)
    else $error("fold latency wrong");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)
    && $stable(out_last))
    else $error("output changed while stalled");
  ready_excl_a: assert property (desc_ready |-> !in_ready)
    else $error("descriptor and input both open");
  seg_flag_a: assert property (out_valid && out_ready && !out_last |=> $stable(out_seg_last))
    else $error("segment last flag moved in frame");
  done_ready_a: assert property (out_valid && out_ready && out_last |-> ##[0:2] desc_ready)
    else $error("block not idle after frame");
endmodule : csum_checker

bind tx_l4_pseudo_header_checksum csum_checker u_chk (.clk(clk), .nrst(nrst),
  .seg_start(seg_start), .desc_ready(desc_ready), .in_valid(in_valid), .in_last(in_last),
  .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
  .out_seg_last(out_seg_last), .out_ready(out_ready));

// [tb/csum_host_model.sv]
`timescale 1ns/10ps

// Host side: feeds segment bytes and drains the output with a stall every third cycle.
module csum_host_model (
  // Clock
  input wire logic clk,
  // Bytes into the block
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_last,
  input wire logic in_ready,
  // Bytes out of the block
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_seg_last,
  output logic out_ready
);
  logic [7:0] mem [0:255];
  logic [7:0] got [0:255];
  logic seg_l;
  int n_got;
  int last_idx;
  int tick;

  // Idle values; the data line starts on a pattern, not a settled zero.
  initial begin
    in_valid = 1'b0;
    in_data = 8'h5a;
    in_last = 1'b0;
    out_ready = 1'b0;
    n_got = 0;
    last_idx = -1;
    tick = 0;
  end

  // In_ready only moves on rising edges, so its value at the falling edge is what gets sampled.
  task send(input int len);
    int k;
    for (k = 0; k < len; k++) begin
      @(negedge clk);
      in_valid = 1'b1;
      in_data = mem[k];
      in_last = (k == len - 1);
      while (in_ready !== 1'b1) @(negedge clk);
    end
    @(negedge clk);
    in_valid = 1'b0;
    in_last = 1'b0;
    in_data = ~in_data; // A released line must not keep showing the last byte.
  endtask : send

  // Ready is set first, so a byte counts as taken when both stand ahead of the coming edge.
  always @(negedge clk) begin
    tick++;
    out_ready = (tick % 3 != 0);
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      got[n_got] = out_data;
      seg_l = out_seg_last;
      if (out_last === 1'b1) last_idx = n_got;
      n_got++;
    end
  end
endmodule : csum_host_model

// [tb/tx_l4_pseudo_header_checksum_tb.sv]
`timescale 1ns/10ps
`include "tx_l4_csum_consts.svh"

// Frames with known contents pass through; the checksum is rebuilt here from the bytes.
module tx_l4_pseudo_header_checksum_tb;
  typedef struct {logic v6; logic udp; logic ins; logic hw; logic rh; logic z; int pay;} row_s;
  logic clk, nrst, seg_start, ipv6_sel, udp_sel, l4_checksum_insert_flag, hw_pseudo;
  logic tso_enable, tso_first, rh_present, desc_ready, in_valid, in_last, in_ready;
  logic out_valid, out_last, out_seg_last, out_ready;
  logic [`PTR_W-1:0] ip_offset, l4_offset, rh_offset;
  logic [15:0] mss;
  logic [19:0] total_payload_length;
  logic [7:0] l4_header_length_field, in_data, out_data;
  logic [7:0] exp [0:255];
  int fails, checks_done, i;
  row_s t;
  row_s rows [9] = '{'{0, 0, 1, 0, 0, 0, 10}, '{0, 1, 1, 1, 0, 0, 6}, '{0, 1, 0, 1, 0, 0, 6},
    '{1, 0, 1, 1, 0, 0, 12}, '{1, 0, 1, 1, 1, 0, 4}, '{1, 1, 1, 1, 1, 0, 4},
    '{1, 1, 1, 1, 0, 1, 4}, '{0, 1, 1, 1, 0, 1, 4}, '{1, 1, 1, 0, 0, 0, 8}};

  tx_l4_pseudo_header_checksum i_tx_l4_pseudo_header_checksum (.clk(clk), .nrst(nrst),
    .seg_start(seg_start), .ipv6_sel(ipv6_sel), .udp_sel(udp_sel),
    .l4_checksum_insert_flag(l4_checksum_insert_flag), .hw_pseudo(hw_pseudo),
    .tso_enable(tso_enable), .tso_first(tso_first), .rh_present(rh_present),
    .ip_offset(ip_offset), .l4_offset(l4_offset), .rh_offset(rh_offset), .mss(mss),
    .total_payload_length(total_payload_length),
    .l4_header_length_field(l4_header_length_field), .desc_ready(desc_ready),
    .in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_seg_last(out_seg_last), .out_ready(out_ready));
  csum_host_model u_host (.clk(clk), .in_valid(in_valid), .in_data(in_data),
    .in_last(in_last), .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .out_seg_last(out_seg_last), .out_ready(out_ready));

  task chk(input string what, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", what, e, g);
      fails++;
    end
  endtask : chk

  // Builds one segment, works out its checksum, sends it and compares every byte.
  task run(input row_s r, input logic tso, input logic first, input int total, input logic lst);
    int l4, hdr, len, cf, k;
    logic [31:0] acc;
    logic [15:0] cs;
    l4 = r.v6 ? (r.rh ? 64 : 40) : 20;
    hdr = r.udp ? 8 : 20;
    len = l4 + hdr + r.pay;
    cf = l4 + (r.udp ? 6 : 16);
    for (k = 0; k < len; k++) exp[k] = 8'(k * 37 + 19);
    exp[41] = 8'h02;
    if (r.udp) {exp[l4+4], exp[l4+5]} = 16'(8 + r.pay);
    else exp[l4+13] = 8'hff;
    if (r.z) {exp[len-2], exp[len-1]} = 16'h0000;
    for (k = 0; k < len; k++) u_host.mem[k] = exp[k];
    if (tso && !lst) exp[l4+13] = 8'hf6;
    acc = 32'(r.udp ? 8 + r.pay : hdr + r.pay);
    for (k = l4; k < len; k += 2) if (!(r.hw && k == cf)) acc += {exp[k], exp[k+1]};
    if (r.hw) begin
      acc += r.udp ? 17 : 6;
      for (k = r.v6 ? 8 : 12; k < (r.v6 ? 40 : 20); k += 2)
        acc += (r.rh && k >= 24) ? {exp[k+24], exp[k+25]} : {exp[k], exp[k+1]};
    end
    acc = {16'h0000, acc[15:0]} + {16'h0000, acc[31:16]};
    acc = {16'h0000, acc[15:0]} + {16'h0000, acc[31:16]};
    if (r.z) begin
      {exp[len-2], exp[len-1]} = ~acc[15:0];
      {u_host.mem[len-2], u_host.mem[len-1]} = ~acc[15:0];
      acc = 32'h0000ffff;
    end
    cs = ~acc[15:0];
    if (r.v6 && r.udp && cs == 16'h0000) cs = 16'hffff;
    if (r.ins) {exp[cf], exp[cf+1]} = cs;
    @(negedge clk);
    while (desc_ready !== 1'b1) @(negedge clk);
    {ipv6_sel, udp_sel, l4_checksum_insert_flag, hw_pseudo} = {r.v6, r.udp, r.ins, r.hw};
    rh_present = r.rh;
    tso_enable = tso;
    tso_first = first;
    l4_offset = 11'(l4);
    total_payload_length = 20'(total);
    l4_header_length_field = 8'(hdr);
    u_host.n_got = 0;
    u_host.last_idx = -1;
    seg_start = 1'b1;
    @(negedge clk);
    seg_start = 1'b0;
    u_host.send(len);
    while (u_host.n_got < len) @(negedge clk);
    for (k = 0; k < len; k++) chk("frame byte", {8'h00, exp[k]}, {8'h00, u_host.got[k]});
    chk("checksum field", {exp[cf], exp[cf+1]}, {u_host.got[cf], u_host.got[cf+1]});
    chk("last marker", 16'(len - 1), 16'(u_host.last_idx));
    chk("segment last", {15'h0000, lst}, {15'h0000, u_host.seg_l});
  endtask : run

  task wrap_up;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // Free-running 50 ns clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // A hang cannot outlast about twenty thousand cycles.
  initial begin
    #1_000_000;
    fails++;
    wrap_up;
  end

  // Reset, the table of single segments, a two-segment job, then a reset between segments and one more segment.
  initial begin
    {nrst, seg_start, ipv6_sel, udp_sel, l4_checksum_insert_flag, hw_pseudo} = 6'h00;
    {tso_enable, tso_first, rh_present} = 3'h0;
    ip_offset = 11'h000;
    rh_offset = 11'h028;
    l4_offset = 11'h014;
    mss = 16'h0008;
    total_payload_length = 20'h00000;
    l4_header_length_field = 8'h14;
    fails = 0;
    checks_done = 0;
    repeat (4) @(negedge clk);
    chk("ready in reset", 16'h0000, {15'h0000, desc_ready});
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    chk("ready after reset", 16'h0001, {15'h0000, desc_ready});
    for (i = 0; i < 9; i++) run(rows[i], 1'b0, 1'b1, rows[i].pay, 1'b1);
    t = '{0, 0, 1, 1, 0, 0, 8};
    run(t, 1'b1, 1'b1, 12, 1'b0);
    t.pay = 4;
    run(t, 1'b1, 1'b0, 12, 1'b1);
    nrst = 1'b0;
    @(negedge clk);
    chk("output in reset", 16'h0000, {15'h0000, out_valid});
    nrst = 1'b1;
    run(rows[3], 1'b0, 1'b1, rows[3].pay, 1'b1);
    wrap_up;
  end
endmodule : tx_l4_pseudo_header_checksum_tb
